// file: rtl/rsc_top.sv
/*
  Radio state controller: takes command bytes from the serial port and steps the
  radio through its power and calibration states.
  Assumes the serial pins are asynchronous to clk and the link clock is much slower.
*/
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_top (
  input  wire logic              clk,             // System clock, 100 MHz.
  input  wire logic              rstn,            // Asynchronous reset, active low.
  input  wire logic              cs_n,            // Serial chip select, active low.
  input  wire logic              sclk,            // Serial link clock.
  input  wire logic              mosi,            // Serial data in, MSB first.
  input  wire logic              pkt_mode,        // 1 packet mode, 0 streaming.
  input  wire logic              skip_synth_cal,  // Skip channel calibration.
  input  wire logic [7:0]        search_delay,    // Receive search delay, cycles.
  input  wire logic              rx_pkt_done,     // Packet received pulse.
  input  wire logic              tx_pkt_done,     // Packet sent pulse.
  output logic                   miso,            // Serial data out, ready flag.
  output logic                   miso_oe_n,       // Data out enable, active low.
  output rsc_pkg::rsc_pwr_t      pwr,             // Block power enables.
  output logic                   cfg_load,        // Load default config pulse.
  output logic                   cfg_access,      // Host may reach config space.
  output logic                   sys_cal,         // System calibration running.
  output logic                   synth_cal,       // Channel calibration running.
  output logic                   cca_run,         // Assessment running.
  output logic                   meas_run,        // Temperature measure running.
  output logic                   preamble_search, // Receiver searching.
  output logic [3:0]             state_code       // Current state.
);
  logic [2:0] cs_s_q;
  logic [2:0] sck_s_q;
  logic [1:0] mosi_s_q;
  logic       cs_lo;
  logic       cs_fall;
  logic       sck_rise;
  logic [7:0] shf_q;
  logic [2:0] bit_q;
  logic       cmd_vld_q;
  logic [7:0] cmd_q;
  logic [15:0] tmr_q;
  logic        tmr_done;
  logic        ld;
  logic [15:0] ld_val;
  logic [7:0]  rxd_q;
  logic        busy_w;
  logic        tmr_ld_q;
  rsc_pkg::rsc_state_t st_q;
  rsc_pkg::rsc_state_t st_d;
  rsc_pkg::rsc_state_t dst_q;
  rsc_pkg::rsc_state_t dst_d;
  rsc_pkg::rsc_state_t ret_q;
  rsc_pkg::rsc_state_t ret_d;

  // Pins pass two flops; the third stage only serves edge detection.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_q   <= 3'h7;
      sck_s_q  <= 3'h0;
      mosi_s_q <= 2'h0;
    end else begin
      cs_s_q   <= {cs_s_q[1:0], cs_n};
      sck_s_q  <= {sck_s_q[1:0], sclk};
      mosi_s_q <= {mosi_s_q[0], mosi};
    end
  end

  assign cs_lo    = !cs_s_q[1];
  assign cs_fall  = cs_s_q[2] && !cs_s_q[1];
  assign sck_rise = !sck_s_q[2] && sck_s_q[1];

  // Command byte assembly, one byte per command.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shf_q     <= 8'h00;
      bit_q     <= 3'h0;
      cmd_vld_q <= 1'b0;
      cmd_q     <= 8'h00;
    end else begin
      cmd_vld_q <= 1'b0;
      if (!cs_lo) begin
        bit_q <= 3'h0;
      end else if (sck_rise) begin
        shf_q <= {shf_q[6:0], mosi_s_q[1]};
        bit_q <= bit_q + 3'h1;
        if (bit_q == `RSC_BIT_LAST) begin
          cmd_q     <= {shf_q[6:0], mosi_s_q[1]};
          cmd_vld_q <= 1'b1;
        end
      end
    end
  end

  assign tmr_done = (tmr_q == 16'h0000);
  assign busy_w   = (st_q == rsc_pkg::ST_POR) || (st_q == rsc_pkg::ST_WAKE) ||
                    (st_q == rsc_pkg::ST_SYSCAL) || (st_q == rsc_pkg::ST_SCAL);

  // Next state: automatic steps first, then host commands.
  always_comb begin
    st_d   = st_q;
    dst_d  = dst_q;
    ret_d  = ret_q;
    ld     = 1'b0;
    ld_val = 16'h0000;
    case (st_q)
      rsc_pkg::ST_OFF: begin
        if (cs_fall) begin
          st_d   = rsc_pkg::ST_POR;
          ld     = 1'b1;
          ld_val = `RSC_POR_CYC;
        end
      end
      rsc_pkg::ST_POR: begin
        if (tmr_done) st_d = rsc_pkg::ST_IDLE;
      end
      rsc_pkg::ST_SLEEP: begin
        if (cs_fall) begin
          st_d   = rsc_pkg::ST_WAKE;
          ld     = 1'b1;
          ld_val = `RSC_WAKE_CYC;
        end
      end
      rsc_pkg::ST_WAKE: begin
        if (tmr_done) st_d = rsc_pkg::ST_IDLE;
      end
      rsc_pkg::ST_SYSCAL: begin
        if (tmr_done) st_d = rsc_pkg::ST_PHY;
      end
      rsc_pkg::ST_SCAL: begin
        if (tmr_done) st_d = dst_q;
      end
      rsc_pkg::ST_CCA: begin
        if (tmr_done) st_d = ret_q;
      end
      rsc_pkg::ST_RX: begin
        if (pkt_mode && rx_pkt_done) st_d = rsc_pkg::ST_PHY;
      end
      rsc_pkg::ST_TX: begin
        if (pkt_mode && tx_pkt_done) st_d = rsc_pkg::ST_PHY;
      end
      default: begin
      end
    endcase
    // Commands outside the listed transitions fall through unchanged.
    if (cmd_vld_q && !busy_w) begin
      case (cmd_q)
        `RSC_CMD_IDLE: begin
          if (st_q != rsc_pkg::ST_SLEEP && st_q != rsc_pkg::ST_OFF) begin
            st_d = rsc_pkg::ST_IDLE;
          end
        end
        `RSC_CMD_PHY: begin
          if (st_q == rsc_pkg::ST_IDLE) begin
            st_d   = rsc_pkg::ST_SYSCAL;
            ld     = 1'b1;
            ld_val = `RSC_SYSCAL_CYC;
          end else if (st_q == rsc_pkg::ST_RX || st_q == rsc_pkg::ST_TX ||
                       st_q == rsc_pkg::ST_CCA) begin
            st_d = rsc_pkg::ST_PHY;
          end
        end
        `RSC_CMD_RX: begin
          if (st_q == rsc_pkg::ST_PHY || st_q == rsc_pkg::ST_TX) begin
            dst_d = rsc_pkg::ST_RX;
            if (skip_synth_cal) begin
              st_d = rsc_pkg::ST_RX;
            end else begin
              st_d   = rsc_pkg::ST_SCAL;
              ld     = 1'b1;
              ld_val = `RSC_SCAL_CYC;
            end
          end else if (st_q == rsc_pkg::ST_CCA) begin
            st_d = rsc_pkg::ST_RX;
          end
        end
        `RSC_CMD_TX: begin
          if (st_q == rsc_pkg::ST_PHY || st_q == rsc_pkg::ST_RX) begin
            dst_d = rsc_pkg::ST_TX;
            if (skip_synth_cal) begin
              st_d = rsc_pkg::ST_TX;
            end else begin
              st_d   = rsc_pkg::ST_SCAL;
              ld     = 1'b1;
              ld_val = `RSC_SCAL_CYC;
            end
          end
        end
        `RSC_CMD_CCA: begin
          if (st_q == rsc_pkg::ST_PHY || st_q == rsc_pkg::ST_RX) begin
            st_d   = rsc_pkg::ST_CCA;
            ret_d  = st_q;
            ld     = 1'b1;
            ld_val = `RSC_CCA_CYC;
          end
        end
        `RSC_CMD_MEAS: begin
          if (st_q == rsc_pkg::ST_IDLE) st_d = rsc_pkg::ST_MEAS;
        end
        `RSC_CMD_SLEEP: begin
          if (st_q != rsc_pkg::ST_OFF && st_q != rsc_pkg::ST_MEAS) begin
            st_d = rsc_pkg::ST_SLEEP;
          end
        end
        default: begin
        end
      endcase
    end
    if (cmd_vld_q && cmd_q == `RSC_CMD_FULL_RESET) begin
      st_d = rsc_pkg::ST_OFF;
      ld   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= rsc_pkg::ST_OFF;
      dst_q <= rsc_pkg::ST_RX;
      ret_q <= rsc_pkg::ST_PHY;
    end else begin
      st_q  <= st_d;
      dst_q <= dst_d;
      ret_q <= ret_d;
    end
  end

  // Shared timer for every timed transition.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_q    <= 16'h0000;
      tmr_ld_q <= 1'b0;
    end else begin
      tmr_ld_q <= ld;
      if (ld) begin
        tmr_q <= ld_val - 16'h0001;
      end else if (!tmr_done) begin
        tmr_q <= tmr_q - 16'h0001;
      end
    end
  end

  // Receive search delay restarts on every receive entry.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxd_q <= 8'h00;
    end else if (st_d == rsc_pkg::ST_RX && st_q != rsc_pkg::ST_RX) begin
      rxd_q <= search_delay;
    end else if (rxd_q != 8'h00) begin
      rxd_q <= rxd_q - 8'h01;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr             <= '0;
      cfg_load        <= 1'b0;
      cfg_access      <= 1'b0;
      sys_cal         <= 1'b0;
      synth_cal       <= 1'b0;
      cca_run         <= 1'b0;
      meas_run        <= 1'b0;
      preamble_search <= 1'b0;
      state_code      <= 4'h0;
    end else begin
      pwr.ldo   <= (st_q != rsc_pkg::ST_OFF) && (st_q != rsc_pkg::ST_SLEEP);
      pwr.xosc  <= (st_q != rsc_pkg::ST_OFF) && (st_q != rsc_pkg::ST_SLEEP);
      pwr.dig   <= (st_q != rsc_pkg::ST_OFF) && (st_q != rsc_pkg::ST_SLEEP);
      pwr.synth <= (st_q == rsc_pkg::ST_SYSCAL) || (st_q == rsc_pkg::ST_PHY) ||
                   (st_q == rsc_pkg::ST_SCAL) || (st_q == rsc_pkg::ST_RX) ||
                   (st_q == rsc_pkg::ST_TX) || (st_q == rsc_pkg::ST_CCA);
      pwr.rx    <= (st_q == rsc_pkg::ST_RX) || (st_q == rsc_pkg::ST_CCA);
      pwr.tx    <= (st_q == rsc_pkg::ST_TX);
      cfg_load  <= (st_q == rsc_pkg::ST_POR) && tmr_done;
      cfg_access <= (st_q == rsc_pkg::ST_IDLE);
      sys_cal   <= (st_q == rsc_pkg::ST_SYSCAL);
      synth_cal <= (st_q == rsc_pkg::ST_SCAL);
      cca_run   <= (st_q == rsc_pkg::ST_CCA);
      meas_run  <= (st_q == rsc_pkg::ST_MEAS);
      preamble_search <= (st_q == rsc_pkg::ST_RX) && (rxd_q == 8'h00);
      state_code <= st_q;
    end
  end

  // Ready flag on data out: high at once unless off, in power-on reset, waking or sleeping.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !cs_lo;
      miso      <= cs_lo && (st_q != rsc_pkg::ST_OFF) && (st_q != rsc_pkg::ST_POR) &&
                   (st_q != rsc_pkg::ST_SLEEP) && (st_q != rsc_pkg::ST_WAKE);
    end
  end

  AST_FULL_RESET:
  assert property (@(posedge clk) disable iff (!rstn)
    cmd_vld_q && cmd_q == `RSC_CMD_FULL_RESET |=> st_q == rsc_pkg::ST_OFF ##1 !pwr.dig)
    else $error("full reset did not shut down");

  AST_POR_LOAD:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_POR && tmr_done |=> cfg_load && st_q == rsc_pkg::ST_IDLE)
    else $error("defaults not loaded on entering idle");

  AST_IDLE_PWR:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_IDLE |=> !pwr.rx && !pwr.tx && pwr.dig && cfg_access)
    else $error("idle power state wrong");

  AST_WAKE:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_SLEEP && cs_fall && !cmd_vld_q
    |=> st_q == rsc_pkg::ST_WAKE ##[1:200] st_q == rsc_pkg::ST_IDLE)
    else $error("sleep wake did not reach idle");

  AST_PHY_SYSCAL:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_IDLE && cmd_vld_q && cmd_q == `RSC_CMD_PHY
    |=> st_q == rsc_pkg::ST_SYSCAL ##1 sys_cal && pwr.synth && !pwr.rx)
    else $error("system calibration missing");

  AST_PHY_NOCAL:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_RX && cmd_vld_q && cmd_q == `RSC_CMD_PHY
    |=> st_q == rsc_pkg::ST_PHY)
    else $error("ready from receive not direct");

  AST_CCA_RET:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_CCA && tmr_done && !cmd_vld_q |=> st_q == $past(ret_q))
    else $error("assessment did not return");

  AST_CCA_FROM_IDLE:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_IDLE && cmd_vld_q && cmd_q == `RSC_CMD_CCA |=> $stable(st_q))
    else $error("assessment taken from idle");

  AST_BUSY_HOLD:
  assert property (@(posedge clk) disable iff (!rstn)
    busy_w && !tmr_done && !tmr_ld_q && cmd_vld_q && cmd_q != `RSC_CMD_FULL_RESET
    |=> st_q == $past(st_q))
    else $error("command taken during transition");

  AST_MEAS_HOLD:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_MEAS && cmd_vld_q && cmd_q == `RSC_CMD_RX |=> st_q == rsc_pkg::ST_MEAS)
    else $error("measure left by other command");

  AST_RX_PKT:
  assert property (@(posedge clk) disable iff (!rstn)
    st_q == rsc_pkg::ST_RX && pkt_mode && rx_pkt_done && !cmd_vld_q
    |=> st_q == rsc_pkg::ST_PHY)
    else $error("packet mode did not return to ready");

  AST_READY_FLAG:
  assert property (@(posedge clk) disable iff (!rstn)
    cs_fall && st_q == rsc_pkg::ST_IDLE |=> miso && !miso_oe_n)
    else $error("ready flag late");

endmodule : rsc_top

// file: rtl/rsc_regs.svh
/*
  Command codes, timing counts and field positions of the radio state controller.
  Assumes inclusion by the controller and by its bench, before any use of the names.
*/
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_CMD_FULL_RESET 8'hC8
`define RSC_CMD_IDLE       8'hB2
`define RSC_CMD_PHY        8'hB3
`define RSC_CMD_RX         8'hB4
`define RSC_CMD_TX         8'hB5
`define RSC_CMD_CCA        8'hB6
`define RSC_CMD_MEAS       8'hB7
`define RSC_CMD_SLEEP      8'hB1
`define RSC_POR_CYC        16'h0040
`define RSC_WAKE_CYC       16'h0080
`define RSC_SYSCAL_CYC     16'h00C8
`define RSC_SCAL_CYC       16'h0028
`define RSC_CCA_CYC        16'h0080
`define RSC_BIT_LAST       3'h7
`endif

// file: rtl/rsc_pkg.sv
/*
  Types shared by the radio state controller and its bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsc_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_POR, ST_SLEEP, ST_WAKE, ST_IDLE, ST_SYSCAL, ST_PHY,
    ST_SCAL, ST_RX, ST_TX, ST_CCA, ST_MEAS
  } rsc_state_t;
  typedef struct packed {
    logic ldo;
    logic xosc;
    logic dig;
    logic synth;
    logic rx;
    logic tx;
  } rsc_pwr_t;
endpackage : rsc_pkg

// file: test/rsc_host.sv
/*
  Host model that drives the serial port of the radio state controller.
  Assumes the bench calls its tasks at falling clk edges and watches the ready flag.
*/
`timescale 1ns/1ns
module rsc_host (
  input  wire logic clk,  // System clock that paces the host.
  input  wire logic miso, // Ready flag as seen on the data-out wire.
  output logic      cs_n, // Chip select, active low.
  output logic      sclk, // Link clock, still outside frames.
  output logic      mosi  // Serial data, MSB first.
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Eight clk periods give half of the 160 ns link period.
  task automatic half_link();
    repeat (8) @(negedge clk);
  endtask : half_link
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      half_link();
      sclk = 1'b1;
      half_link();
      sclk = 1'b0;
    end
  endtask : send_byte
  // Selects the device and waits, bounded, for the ready flag before any command.
  task automatic select(input int lim, output logic ok);
    cs_n = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clk);
      ok = (miso === 1'b1);
    end
  endtask : select
  // A released data line does not keep its last value.
  // Chip select stays high for a half link period so the device sees the gap.
  task automatic release_cs();
    half_link();
    cs_n = 1'b1;
    mosi = ~mosi;
    half_link();
  endtask : release_cs
endmodule : rsc_host

// file: test/radio_state_controller_tb.sv
/*
  Self-checking bench of the radio state controller: directed cases, then random commands.
  Assumes rsc_top, rsc_pkg, rsc_regs.svh and the rsc_host model.
*/
`timescale 1ns/1ns
`include "rsc_regs.svh"
module radio_state_controller_tb;
  logic              clk, rstn, pkt_mode, skip_synth_cal, rx_pkt_done, tx_pkt_done;
  logic [7:0]        search_delay, c;
  logic              cs_n, sclk, mosi, miso, miso_oe_n, host_miso, ok;
  logic              cfg_load, cfg_access, sys_cal, synth_cal, cca_run, meas_run;
  logic              preamble_search, seen_sys, seen_synth, seen_cca;
  logic [3:0]        state_code;
  rsc_pkg::rsc_pwr_t pwr;
  rsc_pkg::rsc_state_t mst;
  int                n_fail, checks_done, n_load, n;
  logic [7:0]        tbl [7];

  rsc_top i_rsc_top (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .pkt_mode(pkt_mode), .skip_synth_cal(skip_synth_cal), .search_delay(search_delay),
    .rx_pkt_done(rx_pkt_done), .tx_pkt_done(tx_pkt_done), .miso(miso),
    .miso_oe_n(miso_oe_n), .pwr(pwr), .cfg_load(cfg_load), .cfg_access(cfg_access),
    .sys_cal(sys_cal), .synth_cal(synth_cal), .cca_run(cca_run), .meas_run(meas_run),
    .preamble_search(preamble_search), .state_code(state_code));
  // An undriven data-out wire reads low at the host.
  assign host_miso = miso_oe_n ? 1'b0 : miso;
  rsc_host i_rsc_host (.clk(clk), .miso(host_miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cfg_load === 1'b1) n_load++;
    if (sys_cal === 1'b1) seen_sys = 1'b1;
    if (synth_cal === 1'b1) seen_synth = 1'b1;
    if (cca_run === 1'b1) seen_cca = 1'b1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic cmd(input logic [7:0] b, input int settle);
    i_rsc_host.send_byte(b);
    repeat (settle) @(negedge clk);
  endtask : cmd

  task automatic pulse(input logic is_rx);
    rx_pkt_done = is_rx;
    tx_pkt_done = !is_rx;
    @(negedge clk);
    rx_pkt_done = 1'b0;
    tx_pkt_done = 1'b0;
    repeat (8) @(negedge clk);
  endtask : pulse

  // Stable state after a command; an assessment returns to where it began.
  function automatic rsc_pkg::rsc_state_t nxt(rsc_pkg::rsc_state_t s, logic [7:0] b);
    case (b)
      `RSC_CMD_IDLE: return rsc_pkg::ST_IDLE;
      `RSC_CMD_PHY: if (s inside {rsc_pkg::ST_IDLE, rsc_pkg::ST_RX, rsc_pkg::ST_TX})
        return rsc_pkg::ST_PHY;
      `RSC_CMD_RX: if (s inside {rsc_pkg::ST_PHY, rsc_pkg::ST_TX}) return rsc_pkg::ST_RX;
      `RSC_CMD_TX: if (s inside {rsc_pkg::ST_PHY, rsc_pkg::ST_RX}) return rsc_pkg::ST_TX;
      `RSC_CMD_MEAS: if (s == rsc_pkg::ST_IDLE) return rsc_pkg::ST_MEAS;
      default: return s;
    endcase
    return s;
  endfunction : nxt

  initial begin
    #600000;
    n_fail++;
    print_verdict();
  end

  initial begin
    tbl = '{`RSC_CMD_IDLE, `RSC_CMD_PHY, `RSC_CMD_RX, `RSC_CMD_TX, `RSC_CMD_CCA,
            `RSC_CMD_MEAS, 8'h5A};
    {rstn, rx_pkt_done, tx_pkt_done, skip_synth_cal} = 4'h0;
    pkt_mode = 1'b1;
    search_delay = 8'h10;
    n_fail = 0;
    checks_done = 0;
    n_load = 0;
    void'($urandom(32'h7424a9ea));
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(state_code, rsc_pkg::ST_OFF);
    chk(miso_oe_n, 1'b1);
    chk(pwr, 16'h0000);
    i_rsc_host.select(300, ok);
    repeat (2) @(negedge clk);
    chk(ok, 1'b1);
    chk(state_code, rsc_pkg::ST_IDLE);
    chk(pwr, 16'h0038);
    chk(cfg_access, 1'b1);
    chk(n_load, 16'h0001);
    cmd(`RSC_CMD_FULL_RESET, 20);
    chk(state_code, rsc_pkg::ST_OFF);
    chk(pwr, 16'h0000);
    i_rsc_host.release_cs();
    i_rsc_host.select(300, ok);
    repeat (2) @(negedge clk);
    chk(n_load, 16'h0002);
    i_rsc_host.release_cs();
    i_rsc_host.select(6, ok);
    chk(ok, 1'b1);
    cmd(`RSC_CMD_MEAS, 20);
    chk({meas_run, state_code}, {1'b1, rsc_pkg::ST_MEAS});
    cmd(`RSC_CMD_PHY, 20);
    chk(state_code, rsc_pkg::ST_MEAS);
    cmd(`RSC_CMD_RX, 20);
    chk(state_code, rsc_pkg::ST_MEAS);
    cmd(`RSC_CMD_IDLE, 20);
    cmd(`RSC_CMD_CCA, 20);
    chk(state_code, rsc_pkg::ST_IDLE);
    seen_sys = 1'b0;
    i_rsc_host.send_byte(`RSC_CMD_PHY);
    cmd(`RSC_CMD_IDLE, 150);
    chk(state_code, rsc_pkg::ST_PHY);
    chk({seen_sys, pwr}, {1'b1, 6'h3C});
    seen_synth = 1'b0;
    cmd(`RSC_CMD_RX, 0);
    for (n = 0; n < 400 && state_code !== rsc_pkg::ST_RX; n++) @(negedge clk);
    for (n = 0; n < 400 && preamble_search !== 1'b1; n++) @(negedge clk);
    chk(n + 3 >= search_delay && n <= search_delay + 3, 1'b1);
    chk(seen_synth, 1'b1);
    seen_cca = 1'b0;
    cmd(`RSC_CMD_CCA, 200);
    chk({seen_cca, state_code}, {1'b1, rsc_pkg::ST_RX});
    pulse(1'b1);
    chk(state_code, rsc_pkg::ST_PHY);
    cmd(`RSC_CMD_RX, 100);
    seen_sys = 1'b0;
    cmd(`RSC_CMD_PHY, 20);
    chk({seen_sys, state_code}, {1'b0, rsc_pkg::ST_PHY});
    cmd(`RSC_CMD_IDLE, 20);
    pkt_mode = 1'b0;
    cmd(`RSC_CMD_PHY, 300);
    cmd(`RSC_CMD_RX, 100);
    pulse(1'b1);
    chk(state_code, rsc_pkg::ST_RX);
    cmd(`RSC_CMD_TX, 100);
    pulse(1'b0);
    chk(state_code, rsc_pkg::ST_TX);
    cmd(`RSC_CMD_IDLE, 20);
    cmd(`RSC_CMD_SLEEP, 20);
    chk(state_code, rsc_pkg::ST_SLEEP);
    i_rsc_host.release_cs();
    i_rsc_host.select(300, ok);
    repeat (2) @(negedge clk);
    chk({ok, state_code}, {1'b1, rsc_pkg::ST_IDLE});
    mst = rsc_pkg::ST_IDLE;
    for (int k = 0; k < 40; k++) begin
      if (mst == rsc_pkg::ST_IDLE) begin
        pkt_mode = 1'($urandom);
        skip_synth_cal = 1'($urandom);
        search_delay = 8'($urandom);
      end
      c = tbl[$urandom_range(6, 0)];
      mst = nxt(mst, c);
      cmd(c, 300);
      chk(state_code, mst);
    end
    print_verdict();
  end
endmodule : radio_state_controller_tb
